// ### core/sqfe_encoder.sv
// Quality and capability field encoder for outgoing surveillance messages.
module sqfe_encoder
  import sqfe_pkg::*;
(
  input  wire logic          sys_clk_in,          // System clock, 100 MHz.
  input  wire logic          rstn_in,             // Asynchronous reset, active low.
  input  wire logic          fix_strobe_in,       // One-cycle pulse: a new fix is on fix_in.
  input  wire sqfe_fix_t     fix_in,              // Fix and its quality figures.
  input  wire sqfe_src_t     src_class_in,        // Class of the attached source.
  input  wire sqfe_cert_t    cert_in,             // Codes from a certified source.
  input  wire logic          aug_avail_in,        // Augmentation signal is received.
  input  wire logic          aug_in_service_in,   // Augmentation is in service.
  output sqfe_quality_t      quality_out,         // Registered message fields.
  output logic               update_out,          // One-cycle pulse: fields refreshed.
  output logic               aug_use_out          // Source told to apply augmentation.
);

  // Complete state of the encoder.
  typedef struct packed {
    sqfe_quality_t quality;   // Fields presently offered to the framer.
    logic          valid;     // Validity seen at the last evaluation.
    logic          update;    // Refresh pulse.
  } sqfe_state_t;

  sqfe_state_t st_q;          // Registered state.
  sqfe_state_t st_d;          // Next state.
  logic [FOM_W-1:0] horiz_merit; // Horizontal merit figure in use.
  logic [FOM_W-1:0] vert_merit;  // Vertical merit figure in use.
  logic [3:0]       pos_cat;     // Position category derived from horiz_merit.
  logic [1:0]       vert_code;   // Vertical code derived from vert_merit.
  logic             evt;      // A new fix or a change of validity.

  // The merit figures come straight from the source when present, else from dilution.
  // Dilution arrives in tenths; the package multiplier already divides that scale out.
  always_comb begin
    if (fix_in.horiz_merit_present) begin
      horiz_merit = fix_in.horiz_merit_figure;
    end else begin
      horiz_merit = FOM_W'(fix_in.horiz_dilution) * DOP_TO_FOM;
    end
    if (fix_in.vert_merit_present) begin
      vert_merit = fix_in.vert_merit_figure;
    end else begin
      vert_merit = FOM_W'(fix_in.vert_dilution) * DOP_TO_FOM;
    end
  end

  // Walk the bounds from coarse to fine so the finest category met wins.
  // A figure equal to a bound fails that bound, so the category drops by one.
  always_comb begin
    pos_cat = 4'h0;
    for (int i = POS_ACC_N - 1; i >= 0; i--) begin
      if (horiz_merit < POS_ACC_LIM[i]) begin
        pos_cat = 4'(POS_ACC_N - i);
      end
    end
  end

  // Vertical code: fine bound gives 2, coarse bound gives 1, otherwise unknown.
  always_comb begin
    if (vert_merit <= VERT_ACC_LIM_FINE) begin
      vert_code = 2'h2;
    end else if (vert_merit <= VERT_ACC_LIM_COARSE) begin
      vert_code = 2'h1;
    end else begin
      vert_code = 2'h0;
    end
  end

  // Fields are recomputed only on a fresh fix or a validity change.
  assign evt = fix_strobe_in | (fix_in.valid != st_q.valid);

  // Next-state logic for the whole encoder.
  always_comb begin
    st_d        = st_q;
    st_d.update = 1'b0;
    // Assurance and capability bits never depend on the fix.
    st_d.quality.design_assurance = SDA_FIXED;
    st_d.quality.capability_bits  = CAP_EQUIPPED;
    if (evt) begin
      st_d.update = 1'b1;
      st_d.valid  = fix_in.valid;
      if (!fix_in.valid) begin
        // A lost or flagged fix zeroes every quality code except design assurance and the capability bits.
        st_d.quality.nav_integrity_category     = 4'h0;
        st_d.quality.source_integrity_level     = 2'h0;
        st_d.quality.velocity_accuracy_category = 3'h0;
        st_d.quality.position_accuracy_category = 4'h0;
        st_d.quality.vertical_accuracy_code     = 2'h0;
      end else begin
        st_d.quality.position_accuracy_category = pos_cat;
        st_d.quality.vertical_accuracy_code     = vert_code;
        if (src_class_in == SQFE_SRC_LOWCOST) begin
          // Low-cost source: fixed integrity and velocity codes.
          st_d.quality.nav_integrity_category     = NAV_INTEG_LOWCOST;
          st_d.quality.source_integrity_level     = SRC_INTEG_LOWCOST;
          st_d.quality.velocity_accuracy_category = VEL_ACC_LOWCOST;
        end else begin
          // Certified source: its own codes under the general rules.
          st_d.quality.nav_integrity_category     = cert_in.nav_integrity_category;
          st_d.quality.source_integrity_level     = cert_in.source_integrity_level;
          st_d.quality.velocity_accuracy_category = cert_in.velocity_accuracy_category;
        end
      end
    end
  end

  // State register; reset shows an invalid position with fixed bits already set.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q                          <= '0;
      st_q.quality.design_assurance <= SDA_FIXED;
      st_q.quality.capability_bits  <= CAP_EQUIPPED;
    end else begin
      st_q <= st_d;
    end
  end

  // Augmentation is used whenever it can be; without it the encoder keeps running.
  assign aug_use_out = aug_avail_in & aug_in_service_in;
  assign quality_out = st_q.quality;
  assign update_out  = st_q.update;

  // Checks on the encoder's own outputs.
  // Each property but p_sda and p_aug samples the event and looks at the fields one cycle later.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  property p_lowcost_nav;
    evt && fix_in.valid && src_class_in == SQFE_SRC_LOWCOST
      |=> quality_out.nav_integrity_category == 4'h6 && update_out;
  endproperty
  a_lowcost_nav: assert property (p_lowcost_nav) else $error("Low-cost integrity category not 6.");

  property p_lowcost_level;
    evt && fix_in.valid && src_class_in == SQFE_SRC_LOWCOST
      |=> quality_out.source_integrity_level == 2'h1;
  endproperty
  a_lowcost_level: assert property (p_lowcost_level) else $error("Low-cost level not 1.");

  property p_invalid_zero;
    evt && !fix_in.valid |=> quality_out.nav_integrity_category == 4'h0
      && quality_out.source_integrity_level == 2'h0;
  endproperty
  a_invalid_zero: assert property (p_invalid_zero) else $error("Invalid fix not zeroed.");

  property p_cert_pass;
    evt && fix_in.valid && src_class_in == SQFE_SRC_CERTIFIED
      |=> quality_out.nav_integrity_category == $past(cert_in.nav_integrity_category)
      && quality_out.source_integrity_level == $past(cert_in.source_integrity_level);
  endproperty
  a_cert_pass: assert property (p_cert_pass) else $error("Certified codes lost.");

  property p_sda;
    quality_out.design_assurance == 2'h1 && quality_out.capability_bits == 2'h1;
  endproperty
  a_sda: assert property (p_sda) else $error("Fixed fields wrong.");

  property p_dilution_pos;
    evt && fix_in.valid && !fix_in.horiz_merit_present && fix_in.horiz_dilution == 8'h19
      |=> quality_out.position_accuracy_category == 4'h8;
  endproperty
  a_dilution_pos: assert property (p_dilution_pos) else $error("Dilution 2.5 not category 8.");

  property p_dilution_vert;
    evt && fix_in.valid && !fix_in.vert_merit_present && fix_in.vert_dilution == 8'h25
      |=> quality_out.vertical_accuracy_code == 2'h2;
  endproperty
  a_dilution_vert: assert property (p_dilution_vert) else $error("Dilution 3.7 not code 2.");

  property p_velocity;
    evt |=> quality_out.velocity_accuracy_category ==
      ($past(fix_in.valid) ? ($past(src_class_in) == SQFE_SRC_LOWCOST ? 3'h1
        : $past(cert_in.velocity_accuracy_category)) : 3'h0);
  endproperty
  a_velocity: assert property (p_velocity) else $error("Velocity category wrong.");

  property p_invalid_acc;
    evt && !fix_in.valid |=> quality_out.position_accuracy_category == 4'h0
      && quality_out.velocity_accuracy_category == 3'h0
      && quality_out.vertical_accuracy_code == 2'h0;
  endproperty
  a_invalid_acc: assert property (p_invalid_acc) else $error("Invalid fix left codes set.");

  property p_update_pulse;
    evt |=> update_out;
  endproperty
  a_update_pulse: assert property (p_update_pulse) else $error("No refresh after event.");

  property p_hold;
    !evt |=> $stable(quality_out) && !update_out;
  endproperty
  a_hold: assert property (p_hold) else $error("Fields moved without event.");

  property p_aug;
    aug_use_out == (aug_avail_in && aug_in_service_in);
  endproperty
  a_aug: assert property (p_aug) else $error("Augmentation use wrong.");

  c_lowcost: cover property (evt && fix_in.valid && src_class_in == SQFE_SRC_LOWCOST);
  c_cert:    cover property (evt && fix_in.valid && src_class_in == SQFE_SRC_CERTIFIED);
  c_lost:    cover property (st_q.valid && !fix_in.valid);
  c_dilute:  cover property (evt && fix_in.valid && !fix_in.horiz_merit_present);
  c_regain:  cover property (evt && !fix_strobe_in && fix_in.valid);

endmodule : sqfe_encoder

// ### shared/sqfe_pkg.sv
// Package of constants and carrier types for the surveillance quality field encoder.
package sqfe_pkg;

  // Width of the figure-of-merit values, in tenths of a metre.
  localparam int FOM_W = 20;
  // Width of the dilution values, in tenths.
  localparam int DOP_W = 8;

  // Assumed range error of 6 metres, held in tenths of a metre.
  localparam int RANGE_ERR_DM = 60;
  // Scale factor applied to dilution times range error.
  localparam int FOM_SCALE = 2;
  // Dilution counts per whole unit of dilution.
  localparam int DOP_SCALE = 10;
  // Combined multiplier from dilution (tenths) to merit figure (tenths of a metre).
  // The dilution scale is divided out, so a dilution of 1.0 gives 12 metres.
  localparam logic [FOM_W-1:0] DOP_TO_FOM = FOM_W'(FOM_SCALE * RANGE_ERR_DM / DOP_SCALE);

  // Fixed codes sent for a low-cost source with a valid fix.
  localparam logic [3:0] NAV_INTEG_LOWCOST = 4'h6;
  localparam logic [1:0] SRC_INTEG_LOWCOST = 2'h1;
  localparam logic [2:0] VEL_ACC_LOWCOST   = 3'h1;
  // Design assurance code, always sent.
  localparam logic [1:0] SDA_FIXED    = 2'h1;
  // Capability pair {bit 53, bit 54}: reserved bit low, equipped bit high.
  localparam logic [1:0] CAP_EQUIPPED = 2'h1;

  // Position accuracy bounds in tenths of a metre, most stringent first.
  // Index i gives category 11 - i when the merit figure is below the bound.
  localparam int POS_ACC_N = 11;
  localparam logic [FOM_W-1:0] POS_ACC_LIM [POS_ACC_N] = '{
    20'h0001E, 20'h00064, 20'h0012C, 20'h0039E, 20'h0073C, 20'h015B4,
    20'h0242C, 20'h04858, 20'h090B0, 20'h12160, 20'h2D370};

  // Vertical accuracy bounds in tenths of a metre (45 m and 150 m).
  localparam logic [FOM_W-1:0] VERT_ACC_LIM_FINE   = 20'h001C2;
  localparam logic [FOM_W-1:0] VERT_ACC_LIM_COARSE = 20'h005DC;

  // Class of the attached position source.
  typedef enum logic {
    SQFE_SRC_LOWCOST   = 1'b0,
    SQFE_SRC_CERTIFIED = 1'b1
  } sqfe_src_t;

  // One fix as delivered by the position source.
  typedef struct packed {
    logic             valid;        // Fix is valid.
    logic             horiz_merit_present; // Horizontal merit figure supplied.
    logic [FOM_W-1:0] horiz_merit_figure;
    logic [DOP_W-1:0] horiz_dilution;
    logic             vert_merit_present;  // Vertical merit figure supplied.
    logic [FOM_W-1:0] vert_merit_figure;
    logic [DOP_W-1:0] vert_dilution;
  } sqfe_fix_t;

  // Codes computed by a certified source under the general rules.
  typedef struct packed {
    logic [3:0] nav_integrity_category;
    logic [1:0] source_integrity_level;
    logic [2:0] velocity_accuracy_category;
  } sqfe_cert_t;

  // Quality and capability fields placed into outgoing messages.
  typedef struct packed {
    logic [3:0] nav_integrity_category;
    logic [1:0] source_integrity_level;
    logic [1:0] design_assurance;
    logic [3:0] position_accuracy_category;
    logic [2:0] velocity_accuracy_category;
    logic [1:0] vertical_accuracy_code;
    logic [1:0] capability_bits;    // Payload bits 21-22 of type code 31.
  } sqfe_quality_t;

endpackage : sqfe_pkg

// ### tb/sqfe_encoder_bench.sv
// Self-checking bench for the quality field encoder.
module sqfe_encoder_bench
  import sqfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // One table row: source setup, fix, and the fields it should produce.
  typedef struct packed {
    sqfe_src_t     src;
    sqfe_cert_t    cert;
    sqfe_fix_t     fix;
    sqfe_quality_t exp;
  } sqfe_row_t;

  localparam sqfe_cert_t    CERT = '{4'h8, 2'h3, 3'h2};  // Certified-source codes.
  localparam sqfe_quality_t RST = '{4'h0, 2'h0, 2'h1, 4'h0, 3'h0, 2'h0, 2'h1}; // Idle fields.
  // Low-cost fix with both dilutions at 25.5, as the source shows after a strobe.
  localparam sqfe_quality_t SCRAMBLED = '{4'h6, 2'h1, 2'h1, 4'h6, 3'h1, 2'h0, 2'h1};
  localparam sqfe_row_t ROWS [8] = '{
    '{SQFE_SRC_LOWCOST, CERT, '{1'b1, 1'b1, 20'h0001D, 8'h00, 1'b1, 20'h001C2, 8'h00},
      '{4'h6, 2'h1, 2'h1, 4'hB, 3'h1, 2'h2, 2'h1}},
    '{SQFE_SRC_LOWCOST, CERT, '{1'b1, 1'b1, 20'h0001E, 8'h00, 1'b1, 20'h001C3, 8'h00},
      '{4'h6, 2'h1, 2'h1, 4'hA, 3'h1, 2'h1, 2'h1}},
    '{SQFE_SRC_LOWCOST, CERT, '{1'b1, 1'b0, 20'h00000, 8'h19, 1'b0, 20'h00000, 8'h25},
      '{4'h6, 2'h1, 2'h1, 4'h8, 3'h1, 2'h2, 2'h1}},
    '{SQFE_SRC_LOWCOST, CERT, '{1'b1, 1'b1, 20'h2D370, 8'h00, 1'b1, 20'h005DD, 8'h00},
      '{4'h6, 2'h1, 2'h1, 4'h0, 3'h1, 2'h0, 2'h1}},
    '{SQFE_SRC_CERTIFIED, CERT, '{1'b1, 1'b1, 20'h0039E, 8'h00, 1'b1, 20'h005DC, 8'h00},
      '{4'h8, 2'h3, 2'h1, 4'h7, 3'h2, 2'h1, 2'h1}},
    '{SQFE_SRC_CERTIFIED, CERT, '{1'b0, 1'b1, 20'h0001D, 8'h00, 1'b1, 20'h00000, 8'h00},
      RST},
    '{SQFE_SRC_LOWCOST, CERT, '{1'b1, 1'b0, 20'h00000, 8'hFF, 1'b0, 20'h00000, 8'h7D},
      '{4'h6, 2'h1, 2'h1, 4'h6, 3'h1, 2'h1, 2'h1}},
    '{SQFE_SRC_LOWCOST, CERT, '{1'b0, 1'b0, 20'h00000, 8'h19, 1'b0, 20'h00000, 8'h0C},
      RST}};

  logic          clk;        // System clock.
  logic          rstn;       // Active-low reset.
  sqfe_src_t     src_class;  // Source class seen by the encoder.
  sqfe_cert_t    cert;       // Certified codes seen by the encoder.
  logic          strobe;     // New-fix pulse from the source.
  sqfe_fix_t     fix;        // Fix from the source.
  logic          aug_av;     // Augmentation received.
  logic          aug_svc;    // Augmentation in service.
  sqfe_quality_t q;          // Encoded fields.
  logic          update;     // Refresh pulse.
  logic          aug_use;    // Augmentation use request.
  int            failures;   // Mismatches seen.
  int            compares;   // Comparisons made.

  sqfe_source_model u_src (.sys_clk_in(clk), .fix_strobe_out(strobe), .fix_out(fix),
    .aug_avail_out(aug_av), .aug_in_service_out(aug_svc));
  sqfe_encoder u_dut (.sys_clk_in(clk), .rstn_in(rstn), .fix_strobe_in(strobe),
    .fix_in(fix), .src_class_in(src_class), .cert_in(cert), .aug_avail_in(aug_av),
    .aug_in_service_in(aug_svc), .quality_out(q), .update_out(update),
    .aug_use_out(aug_use));

  // Free-running 100 MHz clock.
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Compares one value and reports a difference at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Compares every encoded field against the expected set.
  task automatic check_q(input sqfe_quality_t e);
    check(32'(q.nav_integrity_category), 32'(e.nav_integrity_category));
    check(32'(q.source_integrity_level), 32'(e.source_integrity_level));
    check(32'(q.design_assurance), 32'(e.design_assurance));
    check(32'(q.position_accuracy_category), 32'(e.position_accuracy_category));
    check(32'(q.velocity_accuracy_category), 32'(e.velocity_accuracy_category));
    check(32'(q.vertical_accuracy_code), 32'(e.vertical_accuracy_code));
    check(32'(q.capability_bits), 32'(e.capability_bits));
  endtask : check_q

  // Prints the verdict and stops the run.
  task automatic results();
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // Watchdog: the whole sequence needs well under a hundred cycles.
  initial begin
    repeat (1000) @(posedge clk);
    failures++;
    results();
  end

  // Main sequence: reset, table rows, then hold, lost fix, augmentation and re-reset.
  initial begin
    failures = 0;
    compares = 0;
    rstn = 1'b0;
    src_class = SQFE_SRC_LOWCOST;
    cert = CERT;
    repeat (10) @(negedge clk);
    check_q(RST);
    check(32'(update), 32'h0);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      src_class = ROWS[i].src;
      cert = ROWS[i].cert;
      u_src.send(ROWS[i].fix);
      check(32'(update), 32'h1);
      check_q(ROWS[i].exp);
    end
    // Without an event the scrambled figures must not disturb the fields.
    repeat (3) begin
      @(negedge clk);
      check(32'(update), 32'h0);
    end
    check_q(ROWS[7].exp);
    u_src.send(ROWS[0].fix);
    u_src.lose_fix();
    @(negedge clk);
    check(32'(update), 32'h1);
    check_q(RST);
    // The fifth pass reports a type-0 broadcast, which must withhold service.
    for (int k = 0; k < 5; k++) begin
      u_src.set_aug(k[1] | k[2], k[0] | k[2], k[2]);
      #1;
      check(32'(aug_use), 32'(k == 3));
    end
    // A second reset in mid-run returns the idle fields.
    u_src.send(ROWS[4].fix);
    rstn = 1'b0;
    #1;
    check_q(RST);
    check(32'(update), 32'h0);
    @(negedge clk);
    rstn = 1'b1;
    // The source still shows a valid fix, so the first edge after release evaluates it.
    @(negedge clk);
    check(32'(update), 32'h1);
    check_q(SCRAMBLED);
    results();
  end
endmodule : sqfe_encoder_bench

// ### tb/sqfe_source_model.sv
// Behavioural satellite position source that feeds fixes to the encoder.
module sqfe_source_model
  import sqfe_pkg::*;
(
  input  wire logic sys_clk_in,        // Clock shared with the encoder.
  output logic      fix_strobe_out,    // One-cycle pulse: a new fix is offered.
  output sqfe_fix_t fix_out,           // Fix and its quality figures.
  output logic      aug_avail_out,     // Augmentation signal is received.
  output logic      aug_in_service_out // Augmentation is in service.
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet source until the bench asks for traffic.
  initial begin
    fix_strobe_out = 1'b0;
    fix_out = '0;
    aug_avail_out = 1'b0;
    aug_in_service_out = 1'b0;
  end

  // Offers a one-constellation fix with merit or dilution for one cycle.
  // Afterwards the figures are inverted so a late sample shows up; validity stays.
  task automatic send(input sqfe_fix_t f);
    @(negedge sys_clk_in);
    fix_strobe_out <= 1'b1;
    fix_out <= f;
    @(negedge sys_clk_in);
    fix_strobe_out <= 1'b0;
    fix_out <= {f.valid, ~f[$bits(f)-2:0]};
  endtask : send

  // Interference costs the fix: validity falls with no strobe and no bad data.
  task automatic lose_fix();
    @(negedge sys_clk_in);
    fix_out.valid <= 1'b0;
  endtask : lose_fix

  // In-service is withheld while the augmentation satellite broadcasts type 0.
  // Flagged satellites are dropped and both correction kinds applied inside the source.
  task automatic set_aug(input logic avail, svc, type0);
    @(negedge sys_clk_in);
    aug_avail_out <= avail;
    aug_in_service_out <= svc & ~type0;
  endtask : set_aug
endmodule : sqfe_source_model
